/* File: src/rtc_power_window_timer.sv */
`timescale 1ns/100ps
`include "rtc_pwt_defines.svh"
module rtc_power_window_timer
   import rtc_pwt_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // alarm and windows
   input wire logic alarm_event,
   output logic stability_window_active,
   output logic sample_window_active
);
   // ****************************************
   // registers
   // ****************************************
   window_len_t stab_len_reg;
   window_len_t samp_len_reg;
   logic unlock_reg;
   logic pwc_en_reg;
   window_state_e state_reg;
   window_state_e state_next;
   logic [7:0] div_reg;
   logic tick_reg;
   logic stab_out_reg;
   logic samp_out_reg;
   logic [31:0] rdata_reg;

   // ****************************************
   // apb decode
   // ****************************************
   wire access = psel & penable;
   wire sel_pwt = (paddr == `PWT_OFFSET);
   wire sel_cfg = (paddr == `CFG_OFFSET);
   wire sel_stat = (paddr == `STAT_OFFSET);
   wire mapped = sel_pwt | sel_cfg | sel_stat;
   wire wr_en = access & pwrite & mapped;
   wire wr_pwt = wr_en & sel_pwt & unlock_reg;
   wire wr_cfg = wr_en & sel_cfg;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ****************************************
   // power-control clock divider
   // ****************************************
   wire div_wrap = (div_reg == (`PWC_CLK_DIV - 8'h01));
   wire [7:0] div_next = div_wrap ? 8'h00 : div_reg + 8'h01;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         tick_reg <= div_wrap;
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   // lengths are not meant to be trusted after power-on; reset gives zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_len_reg <= 8'(`PWT_RESET >> `PWT_STAB_LSB);
         samp_len_reg <= 8'(`PWT_RESET);
      end else if (wr_pwt) begin
         stab_len_reg <= pwdata[`PWT_STAB_MSB:`PWT_STAB_LSB];
         samp_len_reg <= pwdata[`PWT_SAMP_MSB:`PWT_SAMP_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_reg <= `CFG_UNLOCK_RESET;
         pwc_en_reg <= `CFG_PWC_EN_RESET;
      end else if (wr_cfg) begin
         unlock_reg <= pwdata[`CFG_UNLOCK_BIT];
         pwc_en_reg <= pwdata[`CFG_PWC_EN_BIT];
      end
   end

   // ****************************************
   // window sequencing
   // ****************************************
   wire stab_zero = (stab_len_reg == 8'h00);
   wire samp_zero = (samp_len_reg == 8'h00);
   wire samp_always = (samp_len_reg == `SAMP_ALWAYS);
   wire trigger = alarm_event & pwc_en_reg & (state_reg == ST_IDLE);
   wire abort = ~pwc_en_reg;
   wire stab_start = trigger & ~stab_zero;
   wire stab_expire;
   wire samp_expire;
   wire stab_act;
   wire samp_act;
   window_len_t stab_cnt;
   window_len_t samp_cnt;
   // sample opens on the alarm when stability is zero, else on its expiry
   wire samp_start = (trigger & stab_zero) | stab_expire;

   window_counter stab_ctr (
      .pclk(pclk),
      .presetn(presetn),
      .start(stab_start),
      .abort(abort),
      .tick(tick_reg),
      .length(stab_len_reg),
      .active(stab_act),
      .expire(stab_expire),
      .count(stab_cnt)
   );

   window_counter samp_ctr (
      .pclk(pclk),
      .presetn(presetn),
      .start(samp_start),
      .abort(abort),
      .tick(tick_reg),
      .length(samp_len_reg),
      .active(samp_act),
      .expire(samp_expire),
      .count(samp_cnt)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (trigger && !stab_zero) begin
               state_next = ST_STAB;
            end else if (trigger && !samp_zero) begin
               state_next = ST_SAMP;
            end
         end
         ST_STAB: begin
            if (abort) begin
               state_next = ST_IDLE;
            end else if (stab_expire) begin
               // a zero sample length gives no window at all
               state_next = samp_zero ? ST_IDLE : ST_SAMP;
            end
         end
         ST_SAMP: begin
            if (abort || samp_expire) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // all ones overrides the counter and the enable alike
   wire samp_out_next = (state_next == ST_SAMP) | samp_always;
   wire stab_out_next = (state_next == ST_STAB);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_out_reg <= 1'b0;
         samp_out_reg <= 1'b0;
      end else begin
         stab_out_reg <= stab_out_next;
         samp_out_reg <= samp_out_next;
      end
   end

   assign stability_window_active = stab_out_reg;
   assign sample_window_active = samp_out_reg;

   // ****************************************
   // read data
   // ****************************************
   wire [31:0] pwt_rd = {16'h0000, stab_len_reg, samp_len_reg};
   wire [31:0] cfg_rd = ({31'h0, unlock_reg} << `CFG_UNLOCK_BIT)
                      | ({31'h0, pwc_en_reg} << `CFG_PWC_EN_BIT);
   wire [31:0] stat_rd = ({29'h0, state_reg} << `STAT_STATE_LSB)
                       | ({31'h0, stab_act} << `STAT_STAB_ACT_BIT)
                       | ({31'h0, samp_act} << `STAT_SAMP_ACT_BIT)
                       | ({24'h0, stab_cnt} << `STAT_STAB_CNT_LSB)
                       | ({24'h0, samp_cnt} << `STAT_SAMP_CNT_LSB);
   wire [31:0] rd_mux = sel_pwt ? pwt_rd :
                        sel_cfg ? cfg_rd :
                        sel_stat ? stat_rd : 32'h00000000;

   // read data is registered in the setup cycle so it stands in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         rdata_reg <= rd_mux;
      end
   end

   assign prdata = rdata_reg;
endmodule

/* File: src/rtc_pwt_defines.svh */
`ifndef RTC_PWT_DEFINES_SVH
`define RTC_PWT_DEFINES_SVH

// ****************************************
// register byte addresses
// ****************************************
`define PWT_OFFSET 12'h000
`define CFG_OFFSET 12'h004
`define STAT_OFFSET 12'h008

// ****************************************
// field positions
// ****************************************
`define PWT_STAB_MSB 15
`define PWT_STAB_LSB 8
`define PWT_SAMP_MSB 7
`define PWT_SAMP_LSB 0
`define CFG_UNLOCK_BIT 13
`define CFG_PWC_EN_BIT 0
`define STAT_STATE_LSB 0
`define STAT_STAB_ACT_BIT 4
`define STAT_SAMP_ACT_BIT 5
`define STAT_STAB_CNT_LSB 8
`define STAT_SAMP_CNT_LSB 16

// ****************************************
// reset values
// ****************************************
`define PWT_RESET 16'h0000
`define CFG_UNLOCK_RESET 1'b0
`define CFG_PWC_EN_RESET 1'b0

// ****************************************
// timing: pclk cycles per power-control clock period
// ****************************************
`define PWC_CLK_DIV 8'h19

// sample length that keeps the window open for good
`define SAMP_ALWAYS 8'hff

`endif

/* File: src/rtc_pwt_pkg.sv */
package rtc_pwt_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_STAB = 3'b010,
      ST_SAMP = 3'b100
   } window_state_e;
   typedef logic [7:0] window_len_t;
endpackage

/* File: src/window_counter.sv */
`timescale 1ns/100ps
module window_counter
   import rtc_pwt_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire window_len_t length,
   // status
   output logic active,
   output logic expire,
   output window_len_t count
);
   logic active_reg;
   logic active_next;
   window_len_t count_reg;
   window_len_t count_next;
   wire last_tick = active_reg & tick & (count_reg == 8'h01);

   // ****************************************
   // counter
   // ****************************************
   // a window of n periods closes on the n-th tick after the start
   always_comb begin
      active_next = active_reg;
      count_next = count_reg;
      if (abort) begin
         active_next = 1'b0;
         count_next = 8'h00;
      end else if (start) begin
         active_next = (length != 8'h00);
         count_next = length;
      end else if (active_reg && tick) begin
         count_next = count_reg - 8'h01;
         if (last_tick) begin
            active_next = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_reg <= 1'b0;
         count_reg <= 8'h00;
      end else begin
         active_reg <= active_next;
         count_reg <= count_next;
      end
   end

   assign active = active_reg;
   assign count = count_reg;
   assign expire = last_tick & ~abort & ~start;
endmodule

/* File: sim/rtc_power_window_timer_chk.sv */
`timescale 1ns/100ps
module rtc_power_window_timer_chk
   import rtc_pwt_pkg::*;
(
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // windows
   input wire logic alarm_event,
   input wire logic stability_window_active,
   input wire logic sample_window_active
);
   localparam int DIV = 25;
   logic unl_reg, en_reg;
   logic [15:0] len_reg;
   int sc_reg, pc_reg;
   wire acc = psel && penable;
   wire idle = !stability_window_active && !sample_window_active;
   wire [7:0] st = len_reg[15:8];
   wire [7:0] sa = len_reg[7:0];
   // shadow copy, so no expectation needs a peek inside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unl_reg <= 1'b0;
         en_reg <= 1'b0;
         len_reg <= 16'h0000;
         sc_reg <= 0;
         pc_reg <= 0;
      end else begin
         sc_reg <= stability_window_active ? sc_reg + 1 : 0;
         pc_reg <= sample_window_active ? pc_reg + 1 : 0;
         if (acc && pwrite && paddr == 12'h004) begin
            unl_reg <= pwdata[13];
            en_reg <= pwdata[0];
         end
         if (acc && pwrite && paddr == 12'h000 && unl_reg)
            len_reg <= pwdata[15:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rd_map_a: assert property (
      acc && !pwrite && paddr == 12'h000 |-> prdata == {16'h0000, len_reg}) else $error("bad readback");
   lock_ok_a: assert property (
      acc && pwrite && paddr == 12'h000 |-> !pslverr) else $error("error on timer write");
   ready_a: assert property (
      acc |-> pready) else $error("slave not ready in access phase");
   stab_open_a: assert property (
      alarm_event && en_reg && idle && st != 0 && sa != 8'hff |=> stability_window_active)
      else $error("stability window did not open");
   stab_skip_a: assert property (
      alarm_event && en_reg && idle && st == 0 && sa != 0 |=>
      sample_window_active && !stability_window_active) else $error("no direct sample window");
   hand_off_a: assert property (
      $fell(stability_window_active) && en_reg && $past(en_reg) && sa != 0 |->
      sample_window_active) else $error("sample window late");
   stab_len_a: assert property (
      $fell(stability_window_active) && en_reg && $past(en_reg) |->
      sc_reg >= (st - 1) * DIV && sc_reg <= st * DIV + 1) else $error("stability length wrong");
   samp_len_a: assert property (
      $fell(sample_window_active) && en_reg && $past(en_reg) && sa != 8'hff |->
      pc_reg >= (sa - 1) * DIV && pc_reg <= sa * DIV + 1) else $error("sample length wrong");
   samp_hold_a: assert property (
      sa == 8'hff && $past(sa) == 8'hff |-> sample_window_active) else $error("sample not held");
endmodule
bind rtc_power_window_timer rtc_power_window_timer_chk rtc_power_window_timer_chk_i (.*);

/* File: sim/rtc_power_window_timer_test.sv */
`timescale 1ns/100ps
module rtc_power_window_timer_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alarm_event = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, stability_window_active, sample_window_active;
   logic [15:0] tbl [4] = '{16'h0102, 16'h0201, 16'h0003, 16'hfffe};
   int error_cnt = 0, num_checks = 0;
   rtc_power_window_timer rtc_power_window_timer_i (.*);
   initial forever #10 pclk = ~pclk;
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // pready, prdata and pslverr are taken at the rising edge that ends the access phase
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 50) begin
         @(posedge pclk);
         i++;
      end
      if (pready !== 1'b1) begin
         error_cnt++;
         stop_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic alarm;
      @(posedge pclk);
      alarm_event <= 1'b1;
      @(posedge pclk);
      alarm_event <= 1'b0;
   endtask
   // waits for the window, counts its cycles, compares with n periods
   task automatic win(input bit s, input int n);
      int i, k;
      for (i = 0; i < 3 && !(s ? sample_window_active : stability_window_active); i++)
         @(negedge pclk);
      for (k = 0; k < 7000 && (s ? sample_window_active : stability_window_active); k++)
         @(negedge pclk);
      chk({31'h0, k > 0 && k >= (n - 1) * 25 && k <= n * 25 + 1}, 32'h1);
      if (k >= 7000) begin
         stop_test;
      end
   endtask
   initial begin
      repeat (50000) @(posedge pclk);
      error_cnt++;
      stop_test;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h000, 32'h0);
      rd_chk(12'h008, 32'h00000001);
      apb(1'b1, 12'h000, 32'h1234);
      chk(err, 32'h0);
      rd_chk(12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h2001);
      rd_chk(12'h004, 32'h00002001);
      apb(1'b1, 12'h000, 32'hffffa5c3);
      rd_chk(12'h000, 32'h0000a5c3);
      rd_chk(12'h00c, 32'h0);
      chk(err, 32'h1);
      $display("register test done");
      foreach (tbl[j]) begin
         apb(1'b1, 12'h000, tbl[j]);
         alarm;
         @(negedge pclk);
         if (tbl[j][15:8] != 0) begin
            win(0, tbl[j][15:8]);
            chk(sample_window_active, 32'h1);
         end
         win(1, tbl[j][7:0]);
      end
      $display("window test done");
      apb(1'b1, 12'h004, 32'h2000);
      apb(1'b1, 12'h000, 32'h00ff);
      // the held sample output follows the write by one cycle
      repeat (2) @(negedge pclk);
      chk(sample_window_active, 32'h1);
      apb(1'b1, 12'h000, 32'h0101);
      alarm;
      repeat (3) @(negedge pclk);
      chk(stability_window_active | sample_window_active, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h00ff);
      rd_chk(12'h000, 32'h00000101);
      repeat (2) @(negedge pclk);
      chk(sample_window_active, 32'h0);
      $display("hold test done");
      stop_test;
   end
endmodule
